// >>> src/ssc_pkg.sv
// shared constants and types for the stepper sequencer pair
package ssc_pkg;
	localparam int unsigned SSC_CLK_MHZ = 125;
	localparam int unsigned SSC_WAKE_US = 100;
	localparam int unsigned SSC_WAKE_CYC = SSC_WAKE_US * SSC_CLK_MHZ;
	localparam int unsigned SSC_HALF_STEP_CYC = 4;
	localparam int unsigned SSC_POS_W = 6;
	localparam logic [5:0] SSC_HOME_POS = 6'h00;
	localparam logic [2:0] SSC_MODE_MODE_PIN_DISABLE_STATE = 3'h7;
	localparam logic [2:0] SSC_MODE_FULL = 3'h0;
	localparam logic [2:0] SSC_MODE_HALF = 3'h1;
	localparam logic [2:0] SSC_MODE_QUARTER = 3'h2;
	localparam logic [2:0] SSC_MODE_EIGHTH = 3'h3;
	localparam logic [3:0] SSC_PHASE_HOME = 4'h5;
	localparam logic [5:0] SSC_STEP_FULL = 6'h10;
	localparam logic [5:0] SSC_STEP_HALF = 6'h08;
	localparam logic [5:0] SSC_STEP_QUARTER = 6'h04;
	localparam logic [5:0] SSC_STEP_EIGHTH = 6'h02;
	localparam logic [5:0] SSC_STEP_SIXTEENTH = 6'h01;
	localparam logic [1:0] SSC_PHASE_IDX_LSB = 2'h0;

	typedef enum logic [3:0] {
		SSC_H_IDLE = 4'b0001,
		SSC_H_WAKE = 4'b0010,
		SSC_H_HIGH = 4'b0100,
		SSC_H_LOW = 4'b1000
	} ssc_host_st_t;

	// step size per mode
	function automatic logic [5:0] ssc_step_size(input logic [2:0] mode);
		case (mode)
			SSC_MODE_FULL: ssc_step_size = SSC_STEP_FULL;
			SSC_MODE_HALF: ssc_step_size = SSC_STEP_HALF;
			SSC_MODE_QUARTER: ssc_step_size = SSC_STEP_QUARTER;
			SSC_MODE_EIGHTH: ssc_step_size = SSC_STEP_EIGHTH;
			default: ssc_step_size = SSC_STEP_SIXTEENTH;
		endcase
	endfunction

	// four phase outputs from sequence position (quadrant of 64)
	function automatic logic [3:0] ssc_phases(input logic [5:0] pos);
		case (pos[5:4])
			2'h0: ssc_phases = SSC_PHASE_HOME;
			2'h1: ssc_phases = 4'h6;
			2'h2: ssc_phases = 4'hA;
			default: ssc_phases = 4'h9;
		endcase
	endfunction
endpackage

// >>> src/ssc_if.sv
// pin-level link between host controller and stepper driver logic
`timescale 1ns/1ns
interface ssc_if;
	logic step_clk;
	logic seq_reset;
	logic rotation_direction;
	logic step_mode_select_0;
	logic step_mode_select_1;
	logic step_mode_select_2;
	logic chop_sync;
	logic ref_disable;
	logic sequence_monitor_out;
	logic home_flag_out;

	modport dev (
		input step_clk, seq_reset, rotation_direction, step_mode_select_0, step_mode_select_1,
		step_mode_select_2, chop_sync, ref_disable,
		output sequence_monitor_out, home_flag_out
	);
	modport host (
		output step_clk, seq_reset, rotation_direction, step_mode_select_0, step_mode_select_1,
		step_mode_select_2, chop_sync, ref_disable,
		input sequence_monitor_out, home_flag_out
	);
endinterface

// >>> src/ssc_device.sv
// driver-side sequencer: step edges, direction, sleep modes, phase outputs
// What this block and the host do
// - power-on reset puts sequencer at home
// - reset input returns home; idle held low
// - one increment per qualifying step edge
// - rising only, or both edges variant
// - stopped clock holds state at any level
// - sync input high synchronises chopping
// - host keeps sync off while rotating
// - reference disable high gives first sleep
// - all three mode selects high: second sleep
// - sleep disables power stage outputs
// - first sleep keeps sequencer stepping
// - second sleep freezes sequencer
// - host waits after wake before stepping, except when first sleep ends during a step
// - dual-edge: first edge after wake may fall
// - host ties unused inputs, none floating
// - monitor outputs driven, may float unused
`timescale 1ns/1ns
module ssc_device
	import ssc_pkg::*;
#(
	parameter bit DUAL_EDGE = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	ssc_if.dev lnk,
	output logic [3:0] phase_drive,
	output logic stage_enable,
	output logic chop_sync_en,
	output logic low_power,
	output logic [5:0] seq_position,
	output logic reference_disable_state,
	output logic mode_pin_disable_state
);
	typedef struct packed {
		logic clk_prev;
		logic [5:0] pos;
		logic [3:0] phase;
		logic en;
		logic sync;
		logic lowp;
		logic sl1;
		logic sl2;
		logic mon;
		logic home;
	} ssc_dev_st_t;

	ssc_dev_st_t s_q;
	ssc_dev_st_t s_d;
	logic [2:0] mode;
	logic rise;
	logic fall;
	logic qual;
	logic sl1;
	logic sl2;

	assign mode = {lnk.step_mode_select_2, lnk.step_mode_select_1, lnk.step_mode_select_0};

	always_comb begin
		s_d = s_q;
		rise = lnk.step_clk & ~s_q.clk_prev;
		fall = ~lnk.step_clk & s_q.clk_prev;
		qual = rise | (DUAL_EDGE & fall);
		sl1 = lnk.ref_disable;
		sl2 = (mode == SSC_MODE_MODE_PIN_DISABLE_STATE);
		s_d.clk_prev = lnk.step_clk;
		if (lnk.seq_reset) begin
			s_d.pos = SSC_HOME_POS;
		end else if (qual && !sl2) begin
			if (lnk.rotation_direction) begin
				s_d.pos = s_q.pos - ssc_step_size(mode);
			end else begin
				s_d.pos = s_q.pos + ssc_step_size(mode);
			end
		end
		s_d.sl1 = sl1;
		s_d.sl2 = sl2;
		s_d.en = !(sl1 || sl2);
		s_d.lowp = sl1 || sl2;
		s_d.phase = (sl1 || sl2) ? 4'h0 : ssc_phases(s_d.pos);
		s_d.sync = lnk.chop_sync;
		s_d.mon = (s_d.pos[3:0] == 4'h0);
		s_d.home = (s_d.pos == SSC_HOME_POS);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{clk_prev: 1'b0, pos: SSC_HOME_POS, phase: SSC_PHASE_HOME, en: 1'b1, sync: 1'b0,
				lowp: 1'b0, sl1: 1'b0, sl2: 1'b0, mon: 1'b1, home: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.sequence_monitor_out = s_q.mon;
	assign lnk.home_flag_out = s_q.home;
	assign phase_drive = s_q.phase;
	assign stage_enable = s_q.en;
	assign chop_sync_en = s_q.sync;
	assign low_power = s_q.lowp;
	assign seq_position = s_q.pos;
	assign reference_disable_state = s_q.sl1;
	assign mode_pin_disable_state = s_q.sl2;
endmodule

// >>> src/ssc_host.sv
// host-side controller: wakes, waits, then issues requested steps
`timescale 1ns/1ns
module ssc_host
	import ssc_pkg::*;
#(
	parameter int unsigned WAKE_CYC = SSC_WAKE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_b,
	ssc_if.host lnk,
	input wire logic step_req,
	input wire logic dir_req,
	input wire logic [2:0] mode_req,
	input wire logic sleep_req,
	input wire logic hold_sync_req,
	input wire logic home_req,
	output logic step_ready,
	output logic monitor_seen,
	output logic home_seen
);
	typedef struct packed {
		ssc_host_st_t st;
		logic [23:0] cnt;
		logic clk;
		logic rst;
		logic dir;
		logic [2:0] mode;
		logic sync;
		logic sleep;
		logic rdy;
		logic mon;
		logic home;
	} ssc_hst_st_t;

	ssc_hst_st_t s_q;
	ssc_hst_st_t s_d;
	logic asleep_prev;
	logic asleep_now;

	always_comb begin
		s_d = s_q;
		asleep_prev = s_q.sleep || (s_q.mode == SSC_MODE_MODE_PIN_DISABLE_STATE);
		asleep_now = sleep_req || (mode_req == SSC_MODE_MODE_PIN_DISABLE_STATE);
		s_d.rst = home_req;
		s_d.sleep = sleep_req;
		s_d.mon = lnk.sequence_monitor_out;
		s_d.home = lnk.home_flag_out;
		s_d.rdy = 1'b0;
		case (s_q.st)
			SSC_H_IDLE: begin
				s_d.sync = hold_sync_req;
				s_d.mode = mode_req;
				s_d.dir = dir_req;
				if (asleep_prev && !asleep_now) begin
					s_d.st = SSC_H_WAKE;
					s_d.cnt = 24'h0;
				end else if (step_req) begin
					s_d.sync = 1'b0;
					s_d.clk = 1'b1;
					s_d.cnt = 24'h0;
					s_d.st = SSC_H_HIGH;
				end else begin
					s_d.rdy = 1'b1;
				end
			end
			SSC_H_WAKE: begin
				s_d.mode = mode_req;
				if (asleep_now) begin
					s_d.st = SSC_H_IDLE;
				end else if (s_q.cnt >= WAKE_CYC[23:0] - 24'h1) begin
					s_d.st = SSC_H_IDLE;
				end else begin
					s_d.cnt = s_q.cnt + 24'h1;
				end
			end
			SSC_H_HIGH: begin
				if (s_q.cnt >= SSC_HALF_STEP_CYC[23:0] - 24'h1) begin
					s_d.clk = 1'b0;
					s_d.cnt = 24'h0;
					s_d.st = SSC_H_LOW;
				end else begin
					s_d.cnt = s_q.cnt + 24'h1;
				end
			end
			SSC_H_LOW: begin
				if (s_q.cnt >= SSC_HALF_STEP_CYC[23:0] - 24'h1) begin
					s_d.st = SSC_H_IDLE;
				end else begin
					s_d.cnt = s_q.cnt + 24'h1;
				end
			end
			default: s_d.st = SSC_H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{st: SSC_H_IDLE, cnt: 24'h0, clk: 1'b0, rst: 1'b0, dir: 1'b0, mode: SSC_MODE_FULL,
				sync: 1'b0, sleep: 1'b0, rdy: 1'b0, mon: 1'b0, home: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// every pin always driven to a defined level
	assign lnk.step_clk = s_q.clk;
	assign lnk.seq_reset = s_q.rst;
	assign lnk.rotation_direction = s_q.dir;
	assign lnk.step_mode_select_0 = s_q.mode[0];
	assign lnk.step_mode_select_1 = s_q.mode[1];
	assign lnk.step_mode_select_2 = s_q.mode[2];
	assign lnk.chop_sync = s_q.sync;
	assign lnk.ref_disable = s_q.sleep;
	assign step_ready = s_q.rdy;
	assign monitor_seen = s_q.mon;
	assign home_seen = s_q.home;
endmodule

// >>> bench/ssc_link_sva.sv
// assertions on the host-to-driver pin link
`timescale 1ns/1ns
module ssc_link_sva #(
	parameter int unsigned WAKE_CYC = 10
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic step_clk,
	input wire logic seq_reset,
	input wire logic step_mode_select_0,
	input wire logic step_mode_select_1,
	input wire logic step_mode_select_2,
	input wire logic chop_sync,
	input wire logic ref_disable,
	input wire logic sequence_monitor_out,
	input wire logic home_flag_out
);
	logic mon;
	logic [2:0] ms;
	logic [15:0] wake_q, wake_d;
	assign mon = sequence_monitor_out;
	assign ms = {step_mode_select_2, step_mode_select_1, step_mode_select_0};
	// cycles since the last sleep ended, saturating
	always_comb wake_d = (ref_disable || ms == 3'h7) ? 16'h0000 : wake_q + {15'h0000, wake_q != 16'hFFFF};
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) wake_q <= 16'hFFFF;
		else wake_q <= wake_d;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_HOME: assert property ($rose(rst_b) |-> home_flag_out && mon) else $error("not home after reset");
	AST_RST: assert property (seq_reset |-> ##[1:3] home_flag_out) else $error("reset pin ignored");
	AST_STEP: assert property ($rose(step_clk) && ms == 3'h1 && !ref_disable && !seq_reset && mon
		|-> ##[1:3] !mon) else $error("half step missing");
	AST_SLP1: assert property ($rose(step_clk) && ms == 3'h1 && ref_disable && !seq_reset && mon
		|-> ##[1:3] !mon) else $error("sleep one froze sequencer");
	AST_SLP2: assert property ($rose(step_clk) && ms == 3'h7 && !seq_reset |=> $stable(mon) [*3])
		else $error("sleep two stepped");
	AST_HOLD: assert property ((!seq_reset && $stable(step_clk)) [*4] |=> $stable(mon) && $stable(home_flag_out))
		else $error("state moved without edge");
	AST_SYNC: assert property (step_clk |-> !chop_sync) else $error("sync on while stepping");
	AST_WAKE: assert property ($rose(step_clk) && !ref_disable && ms != 3'h7 |-> wake_q >= WAKE_CYC - 2)
		else $error("step too soon after wake");
	cover property ($rose(step_clk) && ref_disable);
	cover property ($rose(step_clk) && ms == 3'h7);
	cover property ($rose(seq_reset));
endmodule

// >>> bench/tb_stepper_sequencer_control.sv
// self-checking bench for the host and driver pair
`timescale 1ns/1ns
module tb_stepper_sequencer_control import ssc_pkg::*;;
	logic core_clk, rst_b, step_req, dir_req, sleep_req, hold_sync_req, home_req, step_ready, home_seen;
	logic stage_enable, chop_sync_en, low_power, ref_st, pin_st;
	logic [2:0] mode_req;
	logic [3:0] phase_drive;
	logic [5:0] seq_position, exp_pos;
	int bad_count, tests_run;
	ssc_if lnk();
	ssc_host #(.WAKE_CYC(10)) ssc_host_inst(.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk.host),
		.step_req(step_req), .dir_req(dir_req), .mode_req(mode_req), .sleep_req(sleep_req),
		.hold_sync_req(hold_sync_req), .home_req(home_req), .step_ready(step_ready), .monitor_seen(),
		.home_seen(home_seen));
	ssc_device ssc_device_inst(.core_clk(core_clk), .rst_b(rst_b), .lnk(lnk.dev), .phase_drive(phase_drive),
		.stage_enable(stage_enable), .chop_sync_en(chop_sync_en), .low_power(low_power),
		.seq_position(seq_position), .reference_disable_state(ref_st), .mode_pin_disable_state(pin_st));
	ssc_link_sva #(.WAKE_CYC(10)) ssc_link_sva_inst(.core_clk(core_clk), .rst_b(rst_b), .step_clk(lnk.step_clk),
		.seq_reset(lnk.seq_reset), .step_mode_select_0(lnk.step_mode_select_0),
		.step_mode_select_1(lnk.step_mode_select_1), .step_mode_select_2(lnk.step_mode_select_2),
		.chop_sync(lnk.chop_sync), .ref_disable(lnk.ref_disable),
		.sequence_monitor_out(lnk.sequence_monitor_out), .home_flag_out(lnk.home_flag_out));
	task final_report;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [5:0] g, input logic [5:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge core_clk);
			#1;
			i++;
		end while (step_ready !== 1'b1 && i < 300);
		if (i >= 300) begin
			bad_count++;
			$display("ERROR %0t no step ready", $time);
			final_report();
		end
	endtask
	task do_step(input logic [2:0] m, input logic d);
		@(posedge core_clk);
		mode_req <= m;
		dir_req <= d;
		wait_rdy();
		@(posedge core_clk);
		step_req <= 1'b1;
		@(posedge core_clk);
		step_req <= 1'b0;
		repeat (3) @(posedge core_clk);
		wait_rdy();
	endtask
	task t_modes;
		logic [5:0] sz [7];
		sz = '{SSC_STEP_FULL, SSC_STEP_HALF, SSC_STEP_QUARTER, SSC_STEP_EIGHTH, 6'h01, 6'h01, 6'h01};
		for (int k = 0; k < 7; k++) begin
			do_step(3'(k), 1'b0);
			exp_pos += sz[k];
			chk(seq_position, exp_pos);
		end
		do_step(3'h1, 1'b1);
		exp_pos -= SSC_STEP_HALF;
		chk(seq_position, exp_pos);
	endtask
	task t_home;
		@(posedge core_clk);
		home_req <= 1'b1;
		repeat (3) @(posedge core_clk);
		home_req <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
		exp_pos = SSC_HOME_POS;
		chk(seq_position, exp_pos);
		chk({5'h00, home_seen}, 6'h01);
	endtask
	task t_reference_disable_state;
		@(posedge core_clk);
		sleep_req <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk({4'h0, ref_st, stage_enable}, 6'h02);
		chk({1'b0, low_power, phase_drive}, 6'h10);
		do_step(3'h1, 1'b0);
		exp_pos += SSC_STEP_HALF;
		chk(seq_position, exp_pos);
		@(posedge core_clk);
		sleep_req <= 1'b0;
		do_step(3'h1, 1'b0);
		exp_pos += SSC_STEP_HALF;
		chk(seq_position, exp_pos);
	endtask
	task t_mode_pin_disable_state;
		do_step(3'h7, 1'b0);
		chk(seq_position, exp_pos);
		chk({4'h0, pin_st, stage_enable}, 6'h02);
		do_step(3'h0, 1'b0);
		exp_pos += SSC_STEP_FULL;
		chk({stage_enable, seq_position[4:0]}, {1'b1, exp_pos[4:0]});
	endtask
	task t_sync(input logic s);
		@(posedge core_clk);
		hold_sync_req <= s;
		repeat (4) @(posedge core_clk);
		#1;
		chk({5'h00, chop_sync_en}, {5'h00, s});
	endtask
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		{rst_b, step_req, dir_req, sleep_req, hold_sync_req, home_req, mode_req} = '0;
		{bad_count, tests_run} = '0;
		exp_pos = SSC_HOME_POS;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk({2'h0, phase_drive}, {2'h0, SSC_PHASE_HOME});
		t_modes();
		t_home();
		t_reference_disable_state();
		t_mode_pin_disable_state();
		t_sync(1'b1);
		t_sync(1'b0);
		final_report();
	end
endmodule
